// *** flash_engine.sv ***
// Device-side command engine: multi-I/O fast reads, burst wrap, page program.
// Assumes an external array with a combinational read port on the link side
// and a write port on the core side; protection decode lives outside.
`timescale 1ns/10ps

module flash_engine
  import flash_pkg::*;
#(
  parameter int PROG_CYCLES = flash_pkg::PROGRAM_CYCLE_CLKS
) (
  // Core clock and reset
  input  logic                             mclk,
  input  logic                             reset,
  // Link pins
  input  logic                             sclk,
  input  logic                             cs_n,
  input  logic [3:0]                       io_in,
  output logic [3:0]                       io_out,
  output logic [3:0]                       io_oe_n,
  // Status and configuration
  input  logic                             quad_io_enable,
  input  logic                             four_wire_command_mode,
  output logic                             write_enable_latch,
  output logic                             write_in_progress,
  // Array read port, link clock side
  output logic [flash_pkg::ADDR_BITS-1:0]  array_read_addr,
  input  logic [7:0]                       array_rdata,
  // Array program port, core clock side
  output logic [flash_pkg::PAGE_BITS-1:0]  target_page,
  input  logic                             page_protected,
  output logic                             prog_we,
  output logic [flash_pkg::ADDR_BITS-1:0]  prog_addr,
  output logic [7:0]                       prog_data
);
  import flash_pkg::*;

  // ==========================================================================
  // Link side state
  phase_t          st;
  lane_t           lane;
  logic [5:0]      cnt;
  logic [5:0]      last;
  logic [31:0]     sh;
  logic [7:0]      op;
  logic [23:0]     raddr;
  logic [7:0]      hold;
  logic            cont;
  logic            cont_quad;
  logic [2:0]      wrap_setting_bits;
  logic [1:0]      dummy_count_field;
  logic            prog_ok;
  logic [15:0]     ppage;
  logic [7:0]      pidx;
  logic [255:0]    pmask;
  logic [7:0]      page_buf [PAGE_BYTES];
  logic            write_enable_command_tgl;
  logic [3:0]      lsync_a;
  logic [3:0]      lsync_b;

  logic            wel_s;
  logic            wip_s;
  logic            qe_s;
  logic            qpi_s;
  phase_t          st_e;
  lane_t           lane_e;
  logic [5:0]      last_e;
  logic [31:0]     sh_next;
  logic            phase_end;
  logic [7:0]      op_n;
  logic [7:0]      op_e;
  logic [5:0]      qpi_dummy;
  logic            wrap_on;
  logic [7:0]      wmask;
  logic [23:0]     next_raddr;
  logic [7:0]      out_byte;
  logic [7:0]      out_shift;

  assign wel_s = lsync_b[3];
  assign wip_s = lsync_b[2];
  assign qe_s  = lsync_b[1];
  assign qpi_s = lsync_b[0];

  // ==========================================================================
  // Level synchronisers into the link clock
  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      lsync_a <= 4'h0;
      lsync_b <= 4'h0;
    end else begin
      lsync_a <= {write_enable_latch, write_in_progress, quad_io_enable,
                  four_wire_command_mode};
      lsync_b <= lsync_a;
    end
  end

  // ==========================================================================
  // Phase decode
  always_comb begin
    case (dummy_count_field)
      2'h0:    qpi_dummy = FOUR_WIRE_DUMMY_0;
      2'h1:    qpi_dummy = FOUR_WIRE_DUMMY_1;
      2'h2:    qpi_dummy = FOUR_WIRE_DUMMY_2;
      default: qpi_dummy = FOUR_WIRE_DUMMY_3;
    endcase
  end

  always_comb begin
    if (st == ST_IDLE && cont) begin
      st_e   = ST_ADDR;
      lane_e = cont_quad ? LANE4 : LANE2;
      last_e = 6'((ADDR_BITS >> (cont_quad ? 2 : 1)) - 1);
      op_e   = cont_quad ? OP_QUAD_IO : OP_DUAL_IO;
    end else if (st == ST_IDLE) begin
      st_e   = ST_CMD;
      lane_e = qpi_s ? LANE4 : LANE1;
      last_e = qpi_s ? 6'h01 : 6'h07;
      op_e   = op;
    end else begin
      st_e   = st;
      lane_e = lane;
      last_e = last;
      op_e   = op;
    end
  end

  always_comb begin
    case (lane_e)
      LANE1:   sh_next = {sh[30:0], io_in[0]};
      LANE2:   sh_next = {sh[29:0], io_in[1:0]};
      default: sh_next = {sh[27:0], io_in[3:0]};
    endcase
  end

  assign phase_end = (cnt == last_e);
  assign op_n      = sh_next[7:0];

  // Wrap applies only to quad I/O reads outside four-wire mode
  assign wrap_on = (op_e == OP_QUAD_IO) && !qpi_s && !wrap_setting_bits[0];
  assign wmask   = 8'((8'h08 << wrap_setting_bits[2:1]) - 8'h01);

  always_comb begin
    if (wrap_on) begin
      next_raddr = {raddr[23:8], (raddr[7:0] & ~wmask) |
                    (8'(raddr[7:0] + 8'h01) & wmask)};
    end else begin
      next_raddr = 24'(raddr + 24'h000001);
    end
  end

  // ==========================================================================
  // Frame sequencer, cleared whenever select is high
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      st    <= ST_IDLE;
      lane  <= LANE1;
      cnt   <= 6'h00;
      last  <= 6'h00;
      sh    <= 32'h00000000;
      op    <= 8'h00;
      raddr <= 24'h000000;
    end else begin
      sh   <= sh_next;
      st   <= st_e;
      lane <= lane_e;
      last <= last_e;
      op   <= op_e;
      cnt  <= phase_end ? 6'h00 : 6'(cnt + 6'h01);
      if (phase_end) begin
        case (st_e)
          ST_CMD: begin
            op <= op_n;
            st <= ST_IGNORE;
            case (op_n)
              OP_DUAL_OUT, OP_DUAL_IO: begin
                if (!qpi_s) begin
                  st   <= ST_ADDR;
                  lane <= (op_n == OP_DUAL_IO) ? LANE2 : LANE1;
                  last <= (op_n == OP_DUAL_IO) ? 6'h0b : 6'h17;
                end
              end
              OP_QUAD_OUT: begin
                if (!qpi_s && qe_s) begin
                  st   <= ST_ADDR;
                  lane <= LANE1;
                  last <= 6'h17;
                end
              end
              OP_QUAD_IO: begin
                if (qe_s || qpi_s) begin
                  st   <= ST_ADDR;
                  lane <= LANE4;
                  last <= 6'h05;
                end
              end
              OP_FAST: begin
                if (qpi_s) begin
                  st   <= ST_ADDR;
                  lane <= LANE4;
                  last <= 6'h05;
                end
              end
              OP_WRAP_SET: begin
                if (!qpi_s) begin
                  st   <= ST_WRAP;
                  lane <= LANE1;
                  last <= 6'(WRAP_FRAME_BITS - 1);
                end
              end
              OP_READ_PARAM: begin
                st   <= ST_PARAM;
                last <= qpi_s ? 6'h01 : 6'h07;
              end
              OP_PROGRAM: begin
                if (wel_s && !wip_s) begin
                  st   <= ST_ADDR;
                  last <= qpi_s ? 6'h05 : 6'h17;
                end
              end
              default: st <= ST_IGNORE;
            endcase
          end
          ST_ADDR: begin
            raddr <= sh_next[23:0];
            case (op_e)
              OP_DUAL_IO: begin
                st   <= ST_MODE;
                last <= 6'(MODE_CLKS_DUAL - 6'h01);
              end
              OP_QUAD_IO: begin
                st   <= ST_MODE;
                last <= 6'(MODE_CLKS_QUAD - 6'h01);
              end
              OP_PROGRAM: begin
                st   <= ST_PDATA;
                last <= (lane_e == LANE4) ? 6'h01 : 6'h07;
              end
              OP_FAST: begin
                st   <= ST_DUMMY;
                last <= 6'(qpi_dummy - 6'h01);
              end
              default: begin
                st   <= ST_DUMMY;
                last <= 6'(DUMMY_BYTE_CLKS - 6'h01);
              end
            endcase
          end
          ST_MODE: begin
            if (op_e == OP_DUAL_IO) begin
              st   <= ST_RDATA;
              lane <= LANE2;
              last <= 6'h03;
            end else begin
              st   <= ST_DUMMY;
              last <= qpi_s ? 6'(qpi_dummy - MODE_CLKS_QUAD - 6'h01)
                            : 6'(QUAD_DUMMY_CLKS - 6'h01);
            end
          end
          ST_DUMMY: begin
            st   <= ST_RDATA;
            lane <= (op_e == OP_DUAL_OUT) ? LANE2 : LANE4;
            last <= (op_e == OP_DUAL_OUT) ? 6'h03 : 6'h01;
          end
          ST_RDATA: raddr <= next_raddr;
          ST_WRAP, ST_PARAM: st <= ST_IGNORE;
          default: st <= st_e;
        endcase
      end
    end
  end

  // ==========================================================================
  // Persistent link-side settings
  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      cont              <= 1'b0;
      cont_quad         <= 1'b0;
      wrap_setting_bits <= WRAP_RESET;
      dummy_count_field <= DUMMY_FIELD_RESET;
      write_enable_command_tgl          <= 1'b0;
    end else begin
      if (st == ST_IDLE && cont && (io_in | (cont_quad ? 4'h0 : 4'hc)) == 4'hf) begin
        cont <= 1'b0;
      end
      if (st_e == ST_MODE && phase_end) begin
        cont      <= (sh_next[CONT_FIELD_LSB+1:CONT_FIELD_LSB] == CONT_MATCH);
        cont_quad <= (op_e == OP_QUAD_IO);
      end
      if (st_e == ST_WRAP && phase_end) begin
        wrap_setting_bits <= sh_next[WRAP_LEN_LSB+1:WRAP_EN_BIT];
      end
      if (st_e == ST_PARAM && phase_end) begin
        dummy_count_field <= sh_next[DUMMY_FIELD_LSB+1:DUMMY_FIELD_LSB];
      end
      if (st_e == ST_CMD && phase_end && op_n == OP_WRITE_EN) begin
        write_enable_command_tgl <= ~write_enable_command_tgl;
      end
    end
  end

  // ==========================================================================
  // Page buffer capture
  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      prog_ok <= 1'b0;
      ppage   <= 16'h0000;
      pidx    <= 8'h00;
      pmask   <= '0;
    end else begin
      prog_ok <= (st_e == ST_PDATA) && phase_end;
      if (st_e == ST_ADDR && phase_end && op_e == OP_PROGRAM) begin
        ppage <= sh_next[23:8];
        pidx  <= sh_next[7:0];
        pmask <= '0;
      end
      if (st_e == ST_PDATA && phase_end) begin
        pmask[pidx] <= 1'b1;
        pidx        <= 8'(pidx + 8'h01);
      end
    end
  end

  always_ff @(posedge sclk) begin
    if (st_e == ST_PDATA && phase_end) begin
      page_buf[pidx] <= sh_next[7:0];
    end
  end

  assign array_read_addr = raddr;

  // ==========================================================================
  // Read data out on the falling edge
  assign out_byte  = (cnt == 6'h00) ? array_rdata : hold;
  assign out_shift = 8'(out_byte << ((lane == LANE2) ? {cnt[1:0], 1'b0}
                                                     : {cnt[0], 2'h0}));

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      hold    <= 8'h00;
      io_out  <= 4'h0;
      io_oe_n <= 4'hf;
    end else if (st == ST_RDATA) begin
      if (cnt == 6'h00) begin
        hold <= array_rdata;
      end
      if (lane == LANE2) begin
        io_out  <= {2'h0, out_shift[7:6]};
        io_oe_n <= 4'hc;
      end else begin
        io_out  <= out_shift[7:4];
        io_oe_n <= 4'h0;
      end
    end else begin
      io_out  <= 4'h0;
      io_oe_n <= 4'hf;
    end
  end

  // ==========================================================================
  // Core side: crossings and program cycle
  logic [1:0]  cs_sync;
  logic        cs_prev;
  logic [1:0]  ok_sync;
  logic [2:0]  write_enable_command_sync;
  logic        start_chk;
  logic [31:0] timer;
  logic [8:0]  widx;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cs_sync   <= 2'h3;
      cs_prev   <= 1'b1;
      ok_sync   <= 2'h0;
      write_enable_command_sync <= 3'h0;
    end else begin
      cs_sync   <= {cs_sync[0], cs_n};
      cs_prev   <= cs_sync[1];
      ok_sync   <= {ok_sync[0], prog_ok};
      write_enable_command_sync <= {write_enable_command_sync[1:0], write_enable_command_tgl};
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      start_chk   <= 1'b0;
      target_page <= 16'h0000;
    end else begin
      start_chk <= cs_sync[1] && !cs_prev && ok_sync[1] && write_enable_latch
                   && !write_in_progress;
      if (!write_in_progress) begin
        target_page <= ppage;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      write_in_progress <= 1'b0;
      timer             <= 32'h00000000;
      widx              <= 9'h000;
    end else if (start_chk && !page_protected) begin
      write_in_progress <= 1'b1;
      timer             <= 32'(PROG_CYCLES - 1);
      widx              <= 9'h000;
    end else if (write_in_progress) begin
      if (!widx[8]) begin
        widx <= 9'(widx + 9'h001);
      end
      if (timer == 32'h00000000) begin
        write_in_progress <= 1'b0;
      end else begin
        timer <= 32'(timer - 32'h00000001);
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      write_enable_latch <= 1'b0;
    end else if (write_enable_command_sync[2] != write_enable_command_sync[1] && !write_in_progress) begin
      write_enable_latch <= 1'b1;
    end else if (write_in_progress && widx == 9'h0ff) begin
      write_enable_latch <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      prog_we   <= 1'b0;
      prog_addr <= 24'h000000;
      prog_data <= 8'h00;
    end else begin
      prog_we   <= write_in_progress && !widx[8] && pmask[widx[7:0]];
      prog_addr <= {target_page, widx[7:0]};
      prog_data <= page_buf[widx[7:0]];
    end
  end

endmodule

// *** flash_pkg.sv ***
// Constants for the serial flash multi-I/O read and page program engine.
// Assumes a link clock from the host and a local core clock of 125 MHz.
package flash_pkg;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OP_FAST       = 8'h0b;
  localparam logic [7:0] OP_DUAL_OUT   = 8'h3b;
  localparam logic [7:0] OP_QUAD_OUT   = 8'h6b;
  localparam logic [7:0] OP_DUAL_IO    = 8'hbb;
  localparam logic [7:0] OP_QUAD_IO    = 8'heb;
  localparam logic [7:0] OP_WRAP_SET   = 8'h77;
  localparam logic [7:0] OP_READ_PARAM = 8'hc0;
  localparam logic [7:0] OP_PROGRAM    = 8'h02;
  localparam logic [7:0] OP_WRITE_EN   = 8'h06;

  // ==========================================================================
  // Field widths and positions
  localparam int         ADDR_BITS       = 24;
  localparam int         PAGE_BITS       = 16;
  localparam int         PAGE_BYTES      = 256;
  localparam int         WRAP_FRAME_BITS = 32;
  localparam int         WRAP_EN_BIT     = 4;
  localparam int         WRAP_LEN_LSB    = 5;
  localparam int         DUMMY_FIELD_LSB = 4;
  localparam int         CONT_FIELD_LSB  = 4;
  localparam logic [1:0] CONT_MATCH      = 2'h2;

  // ==========================================================================
  // Reset values
  localparam logic [2:0] WRAP_RESET        = 3'h1;
  localparam logic [1:0] DUMMY_FIELD_RESET = 2'h0;

  // ==========================================================================
  // Phase lengths in link clocks
  localparam logic [5:0] DUMMY_BYTE_CLKS = 6'h08;
  localparam logic [5:0] QUAD_DUMMY_CLKS = 6'h04;
  localparam logic [5:0] MODE_CLKS_DUAL  = 6'h04;
  localparam logic [5:0] MODE_CLKS_QUAD  = 6'h02;
  localparam logic [5:0] FOUR_WIRE_DUMMY_0 = 6'h04;
  localparam logic [5:0] FOUR_WIRE_DUMMY_1 = 6'h04;
  localparam logic [5:0] FOUR_WIRE_DUMMY_2 = 6'h06;
  localparam logic [5:0] FOUR_WIRE_DUMMY_3 = 6'h08;

  // ==========================================================================
  // Timing
  localparam int CORE_CLOCK_MHZ     = 125;
  localparam int PROGRAM_CYCLE_US   = 500;
  localparam int PROGRAM_CYCLE_CLKS = PROGRAM_CYCLE_US * CORE_CLOCK_MHZ;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    LANE1 = 2'h0,
    LANE2 = 2'h1,
    LANE4 = 2'h2
  } lane_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_CMD    = 4'h1,
    ST_ADDR   = 4'h2,
    ST_MODE   = 4'h3,
    ST_DUMMY  = 4'h4,
    ST_RDATA  = 4'h5,
    ST_WRAP   = 4'h6,
    ST_PARAM  = 4'h7,
    ST_PDATA  = 4'h8,
    ST_IGNORE = 4'h9
  } phase_t;

endpackage

// *** flash_engine_props.sv ***
// Checker for the flash engine, watching only its ports.
// Assumes it is bound to flash_engine; reset is asynchronous, active high.
`timescale 1ns/10ps

module flash_engine_props #(
  parameter int PROG_CYCLES = 300
) (
  // Core clock and reset
  input logic        mclk,
  input logic        reset,
  // Link and status
  input logic        cs_n,
  input logic [3:0]  io_oe_n,
  input logic        quad_io_enable,
  input logic        four_wire_command_mode,
  input logic        write_enable_latch,
  input logic        write_in_progress,
  // Program port
  input logic        page_protected,
  input logic        prog_we,
  input logic [23:0] prog_addr,
  input logic [15:0] target_page
);
  // ==========================================================================
  // Busy length counter
  logic [31:0] busy_cnt;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      busy_cnt <= '0;
    end else begin
      busy_cnt <= write_in_progress ? busy_cnt + 32'h1 : '0;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  // ==========================================================================
  // Properties
  property p_idle_oe;
    cs_n && $past(cs_n) |-> io_oe_n == 4'hf;
  endproperty
  a_idle_oe: assert property (p_idle_oe) else $error("pins driven while idle");
  property p_oe_legal;
    io_oe_n == 4'hf || io_oe_n == 4'hc || io_oe_n == 4'h0;
  endproperty
  a_oe_legal: assert property (p_oe_legal) else $error("odd pin enable");
  property p_quad;
    !cs_n && io_oe_n == 4'h0 |-> quad_io_enable || four_wire_command_mode;
  endproperty
  a_quad: assert property (p_quad) else $error("quad data without enable");
  property p_needs_latch;
    $rose(write_in_progress) |-> $past(write_enable_latch);
  endproperty
  a_needs_latch: assert property (p_needs_latch) else $error("program without latch");
  property p_protect;
    $rose(write_in_progress) |-> !$past(page_protected);
  endproperty
  a_protect: assert property (p_protect) else $error("protected page programmed");
  property p_we_busy;
    prog_we |-> write_in_progress;
  endproperty
  a_we_busy: assert property (p_we_busy) else $error("write while idle");
  property p_latch_clear;
    $fell(write_in_progress) |-> !write_enable_latch;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch kept");
  property p_same_page;
    prog_we |-> prog_addr[23:8] == target_page;
  endproperty
  a_same_page: assert property (p_same_page) else $error("write left the page");
  property p_cycle_len;
    $fell(write_in_progress) |-> busy_cnt == PROG_CYCLES;
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("program cycle length");
endmodule

bind flash_engine flash_engine_props #(.PROG_CYCLES(PROG_CYCLES)) props_u (
  .mclk(mclk), .reset(reset), .cs_n(cs_n), .io_oe_n(io_oe_n),
  .quad_io_enable(quad_io_enable), .four_wire_command_mode(four_wire_command_mode),
  .write_enable_latch(write_enable_latch), .write_in_progress(write_in_progress),
  .page_protected(page_protected), .prog_we(prog_we), .prog_addr(prog_addr),
  .target_page(target_page)
);

// *** flash_host.sv ***
// Host controller model: drives select, link clock and data pins.
// Assumes each frame is begun just after a core clock edge.
`timescale 1ns/10ps

module flash_host (
  // Link pins
  output logic       sclk,
  output logic       cs_n,
  output logic [3:0] io_in,
  input  logic [3:0] io_out
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io_in = 4'h0;
  end

  // ==========================================================================
  // Frame tasks, clock runs only inside frames
  task automatic beg();
    #3 cs_n = 1'b0;
    #21;
  endtask

  task automatic fin();
    #24 cs_n = 1'b1;
    io_in = ~io_in;
    #96;
  endtask

  task automatic tx(input logic [31:0] v, input int n, input int w);
    logic [3:0] m;
    m = 4'((1 << w) - 1);
    for (int i = n - 1; i >= 0; i--) begin
      io_in = 4'(v >> (i * w)) & m;
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
    end
  endtask

  task automatic rx(output logic [31:0] v, input int n, input int w);
    logic [3:0] m;
    m = 4'((1 << w) - 1);
    v = '0;
    for (int i = 0; i < n; i++) begin
      io_in = ~io_in;
      #24 sclk = 1'b1;
      v = (v << w) | 32'(io_out & m);
      #24 sclk = 1'b0;
    end
  endtask
endmodule

// *** testbench.sv ***
// Testbench for the flash engine with a host model and an array stub.
// Assumes the checker is bound to the engine by its own file.
`timescale 1ns/10ps

module testbench;
  import flash_pkg::*;
  localparam int PC = 300;
  logic        mclk, reset, sclk, cs_n, pwe, page_protected;
  logic        quad_io_enable, four_wire_command_mode, write_enable_latch, write_in_progress;
  logic [3:0]  io_in, io_out, io_oe_n;
  logic [23:0] raddr, paddr, a;
  logic [15:0] tpage;
  logic [7:0]  rdata, pdata;
  logic [7:0]  pmem [logic [23:0]];
  logic [31:0] v;
  int          failures, n_tests;

  flash_engine #(.PROG_CYCLES(PC)) dut_u (
    .mclk(mclk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
    .io_oe_n(io_oe_n), .quad_io_enable(quad_io_enable),
    .four_wire_command_mode(four_wire_command_mode), .write_enable_latch(write_enable_latch),
    .write_in_progress(write_in_progress), .array_read_addr(raddr), .array_rdata(rdata),
    .target_page(tpage), .page_protected(page_protected), .prog_we(pwe), .prog_addr(paddr),
    .prog_data(pdata)
  );
  flash_host host_u (.sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out));

  function automatic logic [7:0] b(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h5a;
  endfunction
  assign rdata = b(raddr);

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (pwe) pmem[paddr] = pdata;
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wait_busy(input logic val, input int lim);
    int k;
    k = 0;
    while (write_in_progress !== val && k < lim) begin
      @(posedge mclk);
      k++;
    end
    if (k == lim) begin
      failures++;
      $display("wrong value at %0t: busy wait ran out", $time);
      close_out();
    end
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_out(input logic [7:0] op, input int w, input logic en);
    @(posedge mclk);
    quad_io_enable <= en;
    repeat (2) @(posedge mclk);
    host_u.beg();
    host_u.tx({op, 24'h0123ff}, 32, 1);
    host_u.tx(0, 8, 1);
    host_u.rx(v, 16 / w, w);
    chk(io_oe_n, !en ? 4'hf : (w == 2 ? 4'hc : 4'h0), "pin enables");
    host_u.fin();
    if (en) chk(v[15:0], {b(24'h0123ff), b(24'h012400)}, "out data");
  endtask

  task automatic t_io(input int w, input logic opc, input logic [23:0] x,
                      input logic [7:0] m, input logic [15:0] e);
    @(posedge mclk);
    host_u.beg();
    if (opc) host_u.tx(w == 4 ? OP_QUAD_IO : OP_DUAL_IO, 8, 1);
    host_u.tx(x, 24 / w, w);
    host_u.tx(m, 8 / w, w);
    host_u.tx(0, w == 4 ? 4 : 0, w);
    host_u.rx(v, 16 / w, w);
    host_u.fin();
    chk(v[15:0], e, "io data");
  endtask

  task automatic t_cmd(input logic [31:0] x, input int n, input int w);
    @(posedge mclk);
    host_u.beg();
    host_u.tx(x, n, w);
    host_u.fin();
  endtask

  task automatic t_fw(input logic [1:0] f, input int nd);
    t_cmd({OP_READ_PARAM, 2'h0, f, 4'h0}, 4, 4);
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      host_u.beg();
      host_u.tx({(k == 0) ? OP_QUAD_IO : OP_FAST, 24'h00053f}, 8, 4);
      host_u.tx(0, nd, 4);
      host_u.rx(v, 4, 4);
      host_u.fin();
      chk(v[15:0], {b(24'h00053f), b(24'h000540)}, "four wire data");
    end
  endtask

  task automatic t_wrap(input logic [7:0] wb);
    @(posedge mclk);
    host_u.beg();
    host_u.tx(OP_WRAP_SET, 8, 1);
    host_u.tx({24'h000000, wb}, 32, 1);
    host_u.fin();
  endtask

  task automatic t_prog(input logic en, input logic prot, input int nbits, input logic ok);
    pmem.delete();
    @(posedge mclk);
    page_protected <= prot;
    if (en) begin
      t_cmd(OP_WRITE_EN, 8, 1);
      repeat (4) @(posedge mclk);
      chk(write_enable_latch, 1'b1, "latch set");
    end
    @(posedge mclk);
    host_u.beg();
    host_u.tx({OP_PROGRAM, 24'h0203ff}, 32, 1);
    host_u.tx(32'ha53c, nbits, 1);
    host_u.fin();
    if (ok) begin
      wait_busy(1'b1, 20);
      chk(tpage, 16'h0203, "page");
      wait_busy(1'b0, PC + 20);
      chk(write_enable_latch, 1'b0, "latch clear");
      chk(pmem.num(), 2, "bytes written");
      chk(pmem[24'h0203ff], 8'ha5, "first byte");
      chk(pmem[24'h020300], 8'h3c, "wrapped byte");
    end else begin
      repeat (20) @(posedge mclk);
      chk(write_in_progress, 1'b0, "refused");
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    reset = 1'b1;
    quad_io_enable = 1'b0;
    four_wire_command_mode = 1'b0;
    page_protected = 1'b0;
    failures = 0;
    n_tests = 0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    repeat (5) @(posedge mclk);
    t_out(OP_DUAL_OUT, 2, 1'b1);
    t_out(OP_QUAD_OUT, 4, 1'b0);
    t_out(OP_QUAD_OUT, 4, 1'b1);
    t_io(2, 1'b1, 24'h0010ff, 8'h20, {b(24'h0010ff), b(24'h001100)});
    t_io(2, 1'b0, 24'h001200, 8'h00, {b(24'h001200), b(24'h001201)});
    t_io(2, 1'b1, 24'h001300, 8'h00, {b(24'h001300), b(24'h001301)});
    t_io(4, 1'b1, 24'h002000, 8'h20, {b(24'h002000), b(24'h002001)});
    t_io(4, 1'b0, 24'h0020ff, 8'h20, {b(24'h0020ff), b(24'h002100)});
    t_cmd(32'hff, 2, 4);
    t_io(4, 1'b1, 24'h002200, 8'h00, {b(24'h002200), b(24'h002201)});
    for (int l = 0; l < 4; l++) begin
      t_wrap({1'b0, 2'(l), 5'h00});
      a = 24'h000500 + 24'(8 << l) - 24'h1;
      t_io(4, 1'b1, a, 8'h00, {b(a), b(24'h000500)});
    end
    @(posedge mclk);
    four_wire_command_mode <= 1'b1;
    // Refused frame lets the mode synchronisers settle
    t_cmd(0, 4, 1);
    for (int f = 0; f < 4; f++) t_fw(2'(f), f < 2 ? 4 : 2 * f + 2);
    @(posedge mclk);
    four_wire_command_mode <= 1'b0;
    t_cmd(0, 4, 1);
    t_io(4, 1'b1, 24'h00053f, 8'h00, {b(24'h00053f), b(24'h000500)});
    t_wrap(8'h10);
    t_io(4, 1'b1, 24'h00053f, 8'h00, {b(24'h00053f), b(24'h000540)});
    t_prog(1'b1, 1'b0, 16, 1'b1);
    t_prog(1'b0, 1'b0, 16, 1'b0);
    t_prog(1'b1, 1'b0, 12, 1'b0);
    t_prog(1'b1, 1'b1, 16, 1'b0);
    close_out();
  end
endmodule
